// ===== design/pcs_map.svh
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
// register offsets on the plain register port
`define PCS_ADDR_PC_LOW       4'h0
`define PCS_ADDR_PC_HIGH_LAT  4'h1
`define PCS_ADDR_PC_UPPER_LAT 4'h2
`define PCS_ADDR_STACK_PTR    4'h3
`define PCS_ADDR_TOS_LOW      4'h4
`define PCS_ADDR_TOS_HIGH     4'h5
`define PCS_ADDR_TOS_UPPER    4'h6
`define PCS_ADDR_CONFIG_LOW   4'h7
// stack pointer register fields
`define PCS_SP_FULL_BIT       7
`define PCS_SP_UNF_BIT        6
`define PCS_SP_TOP            5'h1F
// vectors
`define PCS_RESET_VECTOR      21'h000000
`define PCS_HIGH_VECTOR       21'h000008
`define PCS_LOW_VECTOR        21'h000018
// implemented memory and configuration area (32 Kbyte part)
`define PCS_MEM_TOP           21'h007FFF
`define PCS_CFG_BASE          21'h007FF8
`define PCS_CFG_WORDS         2'h3
`define PCS_CFG_RESET         48'hFFFFFFFFFFFF
`define PCS_CFG_STACK_ERROR_RESET_ENABLE_BIT    0
`define PCS_PC_STEP           21'h000002
`endif

// ===== design/pcs_pkg.sv
package pcs_pkg;
    typedef enum logic [0:0]
    {
        PCS_CFG_LOAD = 1'b0,
        PCS_RUN      = 1'b1
    } pcs_state_t;
endpackage

// ===== design/pcs_pc_stack.sv
`timescale 1ns/10ps
// Summary of operation
// - 21-bit byte program counter; fetches beyond implemented memory return zero.
// - every reset loads the program counter with 0000h.
// - interrupt vectors: 0008h high priority, 0018h low priority.
// - top four program words hold configuration; the first three are copied at every reset.
// - config bytes ascend from word one low byte; fourth word reserved.
// - only pc low byte is visible; upper bits load through holding latches.
// - writing pc low byte also copies both latches into pc.
// - reading pc low byte copies pc high and upper into latches.
// - pc bit 0 always zero; sequential step is 2.
// - calls, gotos, branches load target directly, ignoring latches.
// - push on call and interrupt; pop on returns and extended link ops.
// - calls and returns leave holding latches unchanged.
// - return stack is 31 by 21 bits, 5-bit pointer, outside memory spaces.
// - push increments pointer first, then writes the current pc.
// - pop loads pc from selected entry, then decrements pointer.
// - every reset clears the pointer; pointer zero has no entry.
// - top-of-stack registers read and write the selected entry.
// - software reads and writes the pointer, range 0 to 31.
// - full flag sets after 31 pushes; cleared by software or power-on.
// - with stack reset enabled, 31st push stores, flags full, resets device.
// - with it disabled, pointer stays 31 and extra pushes are dropped.
// - pop at zero loads pc zero, sets underflow, keeps pointer at zero.
// - pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer 4:0.
// - software push stores current pc; software pop just discards the top.
`include "pcs_map.svh"
module pcs_pc_stack
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        soft_reset,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        core_inc,
    input  wire logic        core_jump,
    input  wire logic        core_call,
    input  wire logic [20:0] core_target,
    input  wire logic        core_int_high,
    input  wire logic        core_int_low,
    input  wire logic        core_return,
    input  wire logic        core_ext_return,
    input  wire logic        ext_set_enable,
    input  wire logic        core_push,
    input  wire logic        core_pop,
    output logic      [20:0] prog_addr,
    input  wire logic [15:0] prog_data,
    output logic      [15:0] fetch_word,
    output logic      [20:0] pc,
    output logic             config_busy,
    output logic      [47:0] config_data,
    output logic             stack_reset_pulse
);
    pcs_pkg::pcs_state_t state;
    logic [4:0]  return_stack_pointer;
    logic        stack_full_flag;
    logic        stack_underflow_flag;
    logic [7:0]  pc_high_holding_latch;
    logic [4:0]  pc_upper_holding_latch;
    logic [20:0] stack_mem [1:31];
    logic [1:0]  load_cnt;
    logic        dev_reset;
    logic        do_push;
    logic        do_pop;
    logic        push_room;
    logic        push_last;
    logic        stack_error_reset_enable;
    logic [20:0] tos;
    logic [4:0]  ptr_inc;
    logic        wr_pcl;

    // one decode shared by the write paths
    function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
        reg_hit = (a == off);
    endfunction

    // a core op that changes the stack; at most one per cycle from the core
    assign do_push   = core_call | core_int_high | core_int_low | core_push;
    assign do_pop    = core_return | (core_ext_return & ext_set_enable) | core_pop;
    assign push_room = (return_stack_pointer != `PCS_SP_TOP);
    assign ptr_inc   = return_stack_pointer + 5'h01;
    assign push_last = do_push & (ptr_inc == `PCS_SP_TOP);
    assign stack_error_reset_enable    = config_data[`PCS_CFG_STACK_ERROR_RESET_ENABLE_BIT];
    assign dev_reset = soft_reset | (push_last & stack_error_reset_enable);
    assign tos       = (return_stack_pointer == 5'h00) ? 21'h000000
                                                         : stack_mem[return_stack_pointer];
    assign wr_pcl    = reg_wr & reg_hit(reg_addr, `PCS_ADDR_PC_LOW);

    // configuration copy runs after every reset before the core may run
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state       <= pcs_pkg::PCS_CFG_LOAD;
            load_cnt    <= 2'h0;
            config_busy <= 1'b1;
        end
        else if (dev_reset)
        begin
            state       <= pcs_pkg::PCS_CFG_LOAD;
            load_cnt    <= 2'h0;
            config_busy <= 1'b1;
        end
        else
        begin
            unique case (state)
                pcs_pkg::PCS_CFG_LOAD:
                begin
                    load_cnt <= load_cnt + 2'h1;
                    if (load_cnt == `PCS_CFG_WORDS - 2'h1)
                    begin
                        state       <= pcs_pkg::PCS_RUN;
                        config_busy <= 1'b0;
                    end
                end
                pcs_pkg::PCS_RUN:
                begin
                    load_cnt    <= 2'h0;
                    config_busy <= 1'b0;
                end
            endcase
        end
    end

    // configuration words ascend: word one low byte at the lowest address
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            config_data <= `PCS_CFG_RESET;
        else if (state == pcs_pkg::PCS_CFG_LOAD && !dev_reset)
            config_data[load_cnt*16 +: 16] <= prog_data;
    end

    // program address: config area while loading, else the pc
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            prog_addr <= `PCS_CFG_BASE;
        else if (dev_reset)
            prog_addr <= `PCS_CFG_BASE;
        else if (state == pcs_pkg::PCS_CFG_LOAD && load_cnt != `PCS_CFG_WORDS - 2'h1)
            prog_addr <= `PCS_CFG_BASE + {18'h00000, load_cnt + 2'h1, 1'b0};
        else
            prog_addr <= pc;
    end

    // unimplemented space reads as zero, which decodes as a no-op
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            fetch_word <= 16'h0000;
        else if (prog_addr > `PCS_MEM_TOP || state != pcs_pkg::PCS_RUN)
            fetch_word <= 16'h0000;
        else
            fetch_word <= prog_data;
    end

    // config_busy is kept in the state process so the output comes from a flop
    // program counter; bit 0 is never written with a one
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pc <= `PCS_RESET_VECTOR;
        else if (dev_reset)
            pc <= `PCS_RESET_VECTOR;
        else if (core_int_high)
            pc <= `PCS_HIGH_VECTOR;
        else if (core_int_low)
            pc <= `PCS_LOW_VECTOR;
        else if (core_call | core_jump)
            pc <= {core_target[20:1], 1'b0};
        else if ((core_return | (core_ext_return & ext_set_enable)) &&
                 return_stack_pointer == 5'h00)
            pc <= 21'h000000;
        else if (core_return | (core_ext_return & ext_set_enable))
            pc <= {tos[20:1], 1'b0};
        else if (wr_pcl)
            pc <= {pc_upper_holding_latch, pc_high_holding_latch,
                   reg_wdata[7:1], 1'b0};
        else if (core_inc)
            pc <= pc + `PCS_PC_STEP;
    end

    // holding latches: bus writes, and filled by a pc low byte read only
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pc_high_holding_latch  <= 8'h00;
            pc_upper_holding_latch <= 5'h00;
        end
        else if (reg_rd && reg_hit(reg_addr, `PCS_ADDR_PC_LOW))
        begin
            pc_high_holding_latch  <= pc[15:8];
            pc_upper_holding_latch <= pc[20:16];
        end
        else if (reg_wr && reg_hit(reg_addr, `PCS_ADDR_PC_HIGH_LAT))
            pc_high_holding_latch <= reg_wdata;
        else if (reg_wr && reg_hit(reg_addr, `PCS_ADDR_PC_UPPER_LAT))
            pc_upper_holding_latch <= reg_wdata[4:0];
    end

    // stack pointer; core ops outrank a bus write in the same cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            return_stack_pointer <= 5'h00;
        else if (dev_reset)
            return_stack_pointer <= 5'h00;
        else if (do_push && push_room)
            return_stack_pointer <= ptr_inc;
        else if (do_pop && return_stack_pointer != 5'h00)
            return_stack_pointer <= return_stack_pointer - 5'h01;
        else if (!do_push && !do_pop && reg_wr && reg_hit(reg_addr, `PCS_ADDR_STACK_PTR))
            return_stack_pointer <= reg_wdata[4:0];
    end

    // flags survive soft and overflow resets; set wins over a clearing write
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stack_full_flag      <= 1'b0;
            stack_underflow_flag <= 1'b0;
        end
        else
        begin
            if (push_last || (do_push && !push_room))
                stack_full_flag <= 1'b1;
            else if (reg_wr && reg_hit(reg_addr, `PCS_ADDR_STACK_PTR))
                stack_full_flag <= stack_full_flag & reg_wdata[`PCS_SP_FULL_BIT];
            if (do_pop && return_stack_pointer == 5'h00)
                stack_underflow_flag <= 1'b1;
            else if (reg_wr && reg_hit(reg_addr, `PCS_ADDR_STACK_PTR))
                stack_underflow_flag <= stack_underflow_flag & reg_wdata[`PCS_SP_UNF_BIT];
        end
    end

    // stack array; entry zero does not exist, full stack drops the write
    always_ff @(posedge clk)
    begin
        if (!reset && do_push && push_room)
            stack_mem[ptr_inc] <= pc;
        else if (!reset && reg_wr && return_stack_pointer != 5'h00)
        begin
            if (reg_hit(reg_addr, `PCS_ADDR_TOS_LOW))
                stack_mem[return_stack_pointer][7:0] <= reg_wdata;
            else if (reg_hit(reg_addr, `PCS_ADDR_TOS_HIGH))
                stack_mem[return_stack_pointer][15:8] <= reg_wdata;
            else if (reg_hit(reg_addr, `PCS_ADDR_TOS_UPPER))
                stack_mem[return_stack_pointer][20:16] <= reg_wdata[4:0];
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (!reg_rd)
            reg_rdata <= 8'h00;
        else
        begin
            unique case (reg_addr)
                `PCS_ADDR_PC_LOW:       reg_rdata <= pc[7:0];
                `PCS_ADDR_PC_HIGH_LAT:  reg_rdata <= pc_high_holding_latch;
                `PCS_ADDR_PC_UPPER_LAT: reg_rdata <= {3'h0, pc_upper_holding_latch};
                `PCS_ADDR_STACK_PTR:    reg_rdata <= {stack_full_flag, stack_underflow_flag,
                                                      1'b0, return_stack_pointer};
                `PCS_ADDR_TOS_LOW:      reg_rdata <= tos[7:0];
                `PCS_ADDR_TOS_HIGH:     reg_rdata <= tos[15:8];
                `PCS_ADDR_TOS_UPPER:    reg_rdata <= {3'h0, tos[20:16]};
                `PCS_ADDR_CONFIG_LOW:   reg_rdata <= config_data[7:0];
                default:                reg_rdata <= 8'h00;
            endcase
        end
    end

    // overflow reset is signalled so the rest of the device can follow
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            stack_reset_pulse <= 1'b0;
        else
            stack_reset_pulse <= push_last & stack_error_reset_enable;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_push_at_top;
        do_push && return_stack_pointer == 5'h1E && stack_error_reset_enable;
    endsequence

    a_reset_vector_pc: assert property (soft_reset |=> pc == 21'h000000)
        else $error("pc not at reset vector after reset");
    a_high_vector_load: assert property (core_int_high && !soft_reset && !push_last
                                         |=> pc == 21'h000008)
        else $error("high vector not loaded");
    a_low_vector_load: assert property (core_int_low && !core_int_high && !dev_reset
                                        |=> pc == 21'h000018)
        else $error("low vector not loaded");
    a_pc_bit_zero: assert property (pc[0] == 1'b0)
        else $error("pc bit 0 set");
    a_pc_step_two: assert property (core_inc && !core_jump && !core_call && !do_pop &&
                                    !wr_pcl && !core_int_high && !core_int_low &&
                                    !dev_reset && state == pcs_pkg::PCS_RUN
                                    |=> pc == $past(pc) + 21'h000002)
        else $error("sequential step not 2");
    a_latch_on_read: assert property (reg_rd && reg_addr == 4'h0
                                      |=> pc_high_holding_latch == $past(pc[15:8]))
        else $error("latch not loaded from pc");
    a_pcl_write_copy: assert property (wr_pcl && !do_push && !do_pop && !core_jump &&
                                       !core_inc && !dev_reset
                                       |=> pc[20:16] == $past(pc_upper_holding_latch))
        else $error("latch not copied on pc low write");
    a_push_stores_pc: assert property (do_push && push_room && !dev_reset
                                       |=> tos == $past(pc))
        else $error("push did not store pc");
    a_overflow_reset: assert property (s_push_at_top |=> return_stack_pointer == 5'h00
                                       && stack_full_flag && stack_reset_pulse)
        else $error("overflow reset wrong");
    a_full_no_advance: assert property (do_push && !push_room && !dev_reset
                                        |=> return_stack_pointer == 5'h1F
                                        && stack_full_flag)
        else $error("pointer moved past 31");
    a_underflow_pop: assert property (core_return && return_stack_pointer == 5'h00 &&
                                      !dev_reset && !core_int_high && !core_int_low &&
                                      !core_call && !core_jump
                                      |=> pc == 21'h000000 && stack_underflow_flag
                                      && return_stack_pointer == 5'h00)
        else $error("underflow pop wrong");
    a_config_done: assert property (dev_reset |=> config_busy [*3] ##1 !config_busy)
        else $error("config load length wrong");

    // a pop that finds an entry, with nothing else touching the pointer
    sequence s_pop_nonempty;
        do_pop && return_stack_pointer != 5'h00 && !do_push && !dev_reset;
    endsequence

    // software pop only discards, the pc keeps its value
    a_pop_keeps_pc: assert property (core_pop && !core_inc && !core_jump && !core_call &&
                                     !core_int_high && !core_int_low && !core_return &&
                                     !core_ext_return && !wr_pcl && !dev_reset
                                     |=> pc == $past(pc))
        else $error("software pop changed pc");
    // direct loads ignore the holding latches entirely
    a_jump_direct: assert property (core_jump && !core_int_high && !core_int_low && !dev_reset
                                    |=> pc == {$past(core_target[20:1]), 1'b0})
        else $error("jump target not loaded");
    // stack ops never disturb the latches
    a_latch_hold_call: assert property ((do_push || do_pop) && !reg_wr && !reg_rd
                                        |=> $stable(pc_high_holding_latch) &&
                                            $stable(pc_upper_holding_latch))
        else $error("latch changed by call or return");
    // fetches beyond the part must decode as a no-op
    a_fetch_zero_high: assert property (prog_addr > 21'h007FFF |=> fetch_word == 16'h0000)
        else $error("fetch above memory not zero");
    // a pointer write lands when no core op competes
    a_sp_write: assert property (reg_wr && reg_addr == 4'h3 && !do_push && !do_pop && !dev_reset
                                 |=> return_stack_pointer == $past(reg_wdata[4:0]))
        else $error("pointer write lost");
    a_pop_decrements: assert property (s_pop_nonempty
                                       |=> return_stack_pointer == $past(return_stack_pointer)
                                           - 5'h01)
        else $error("pop did not decrement pointer");
    // the flags are sticky, only a pointer register write or power-on reset may clear them
    a_full_sticky: assert property (stack_full_flag && !(reg_wr && reg_addr == 4'h3)
                                    |=> stack_full_flag)
        else $error("full flag dropped");
    a_unf_sticky: assert property (stack_underflow_flag && !(reg_wr && reg_addr == 4'h3)
                                   |=> stack_underflow_flag)
        else $error("underflow flag dropped");
    // any device reset leaves the pointer empty
    a_sp_reset_zero: assert property (dev_reset |=> return_stack_pointer == 5'h00)
        else $error("pointer not cleared by reset");
endmodule

// ===== tb/pcs_prog_mem.sv
`timescale 1ns/10ps
module pcs_prog_mem
(
    input  wire logic [20:0] prog_addr,
    input  wire logic [15:0] cfg_one,
    output logic      [15:0] prog_data
);
    // config words ascend from the low byte of word one, fourth word left erased
    // addresses past the part still answer a pattern, so zero fill must come from the pc side
    always_comb
    begin
        case (prog_addr)
            21'h007FF8: prog_data = cfg_one;
            21'h007FFA: prog_data = 16'h1234;
            21'h007FFC: prog_data = 16'h5678;
            21'h007FFE: prog_data = 16'hFFFF;
            default:    prog_data = prog_addr[16:1] ^ 16'h5A5A;
        endcase
    end
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
    typedef struct packed
    {
        logic [3:0]  op;
        logic        ext;
        logic [20:0] tgt;
        logic [20:0] epc;
        logic [7:0]  esp;
    } pcs_tb_row_t;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        soft_reset = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [8:0]  op_v = 9'h000;
    logic [20:0] core_target = 21'h000000;
    logic        ext_set_enable = 1'b0;
    logic [20:0] prog_addr;
    logic [15:0] prog_data;
    logic [15:0] fetch_word;
    logic [20:0] pc;
    logic        config_busy;
    logic [47:0] config_data;
    logic        stack_reset_pulse;
    logic [15:0] cfg_one = 16'hFFFF;
    logic [7:0]  rv;
    int          pulse_count = 0;
    int          mismatches = 0;
    int          total_checks = 0;
    int          i;
    // ops: 0 inc 1 jump 2 call 3 int high 4 int low 5 return 6 ext return 7 push 8 pop
    pcs_tb_row_t rows [12] = '{
        '{4'h0, 1'b0, 21'h0, 21'h000002, 8'h00}, '{4'h1, 1'b0, 21'h001235, 21'h001234, 8'h00},
        '{4'h2, 1'b0, 21'h000100, 21'h000100, 8'h01}, '{4'h3, 1'b0, 21'h0, 21'h000008, 8'h02},
        '{4'h4, 1'b0, 21'h0, 21'h000018, 8'h03}, '{4'h5, 1'b0, 21'h0, 21'h000008, 8'h02},
        '{4'h6, 1'b0, 21'h0, 21'h000008, 8'h02}, '{4'h6, 1'b1, 21'h0, 21'h000100, 8'h01},
        '{4'h7, 1'b0, 21'h0, 21'h000100, 8'h02}, '{4'h8, 1'b0, 21'h0, 21'h000100, 8'h01},
        '{4'h5, 1'b0, 21'h0, 21'h001234, 8'h00}, '{4'h5, 1'b0, 21'h0, 21'h000000, 8'h40}};

    pcs_pc_stack i_pcs_pc_stack
    (
        .clk               (clk),
        .reset             (reset),
        .soft_reset        (soft_reset),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata         (reg_rdata),
        .core_inc          (op_v[0]),
        .core_jump         (op_v[1]),
        .core_call         (op_v[2]),
        .core_target       (core_target),
        .core_int_high     (op_v[3]),
        .core_int_low      (op_v[4]),
        .core_return       (op_v[5]),
        .core_ext_return   (op_v[6]),
        .ext_set_enable    (ext_set_enable),
        .core_push         (op_v[7]),
        .core_pop          (op_v[8]),
        .prog_addr         (prog_addr),
        .prog_data         (prog_data),
        .fetch_word        (fetch_word),
        .pc                (pc),
        .config_busy       (config_busy),
        .config_data       (config_data),
        .stack_reset_pulse (stack_reset_pulse)
    );

    pcs_prog_mem i_pcs_prog_mem
    (
        .prog_addr (prog_addr),
        .cfg_one   (cfg_one),
        .prog_data (prog_data)
    );

    // free running core clock
    always #4 clk = ~clk;

    // count overflow resets, the pulse lasts a single cycle
    always @(posedge clk)
    begin
        if (stack_reset_pulse === 1'b1)
            pulse_count <= pulse_count + 1;
    end

    task summarize;
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one core op pulse; #1 lets the taking edge settle before anyone looks
    task op(input int k, input logic e, input logic [20:0] t);
        @(posedge clk);
        op_v <= 9'h001 << k;
        ext_set_enable <= e;
        core_target <= t;
        @(posedge clk);
        op_v <= 9'h000;
        #1;
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // wait out the config copy; busy may start an edge late after a sync reset
    task idle;
        for (i = 0; i < 4 && config_busy !== 1'b1; i++)
            @(posedge clk);
        for (i = 0; i < 20 && config_busy !== 1'b0; i++)
            @(posedge clk);
        if (config_busy !== 1'b0)
        begin
            mismatches++;
            summarize();
        end
        #1;
    endtask

    task sync_reset;
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        idle();
    endtask

    // 31 pushes with a step between, so every entry differs (last one stores 3Ch)
    task fill;
        for (int j = 0; j < 31; j++)
        begin
            op(7, 1'b0, 21'h0);
            if (j < 30)
                op(0, 1'b0, 21'h0);
        end
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd(4'h3, rv);
        chk(rv, 8'h00);
        chk(pc, 21'h0);
        idle();
        chk(config_data, {16'h5678, 16'h1234, 16'hFFFF});
        foreach (rows[r])
        begin
            op(rows[r].op, rows[r].ext, rows[r].tgt);
            chk(pc, rows[r].epc);
            rd(4'h3, rv);
            chk(rv, rows[r].esp);
        end
        wr(4'h3, 8'h00);
        rd(4'h3, rv);
        chk(rv, 8'h00);
        wr(4'hA, 8'h55);
        rd(4'hA, rv);
        chk(rv, 8'h00);
        wr(4'h1, 8'h12);
        wr(4'h2, 8'h03);
        wr(4'h0, 8'h45);
        chk(pc, 21'h031244);
        op(1, 1'b0, 21'h0ABCDE);
        chk(pc, 21'h0ABCDE);
        rd(4'h0, rv);
        chk(rv, 8'hDE);
        op(2, 1'b0, 21'h000300);
        rd(4'h4, rv);
        chk(rv, 8'hDE);
        rd(4'h5, rv);
        chk(rv, 8'hBC);
        rd(4'h6, rv);
        chk(rv, 8'h0A);
        wr(4'h4, 8'h40);
        wr(4'h5, 8'h05);
        wr(4'h6, 8'h00);
        op(5, 1'b0, 21'h0);
        chk(pc, 21'h000540);
        wr(4'h0, 8'h11);
        chk(pc, 21'h0ABC10);
        op(1, 1'b0, 21'h100000);
        repeat (2) @(posedge clk);
        #1;
        chk(fetch_word, 16'h0000);
        chk(prog_addr, 21'h100000);
        op(1, 1'b0, 21'h000200);
        repeat (2) @(posedge clk);
        #1;
        chk(fetch_word, 16'h5B5A);
        wr(4'h3, 8'h05);
        rd(4'h3, rv);
        chk(rv, 8'h05);
        sync_reset();
        rd(4'h3, rv);
        chk(rv, 8'h00);
        chk(pc, 21'h0);
        fill();
        idle();
        chk(48'(pulse_count), 48'h1);
        rd(4'h3, rv);
        chk(rv, 8'h80);
        chk(pc, 21'h0);
        wr(4'h3, 8'h00);
        cfg_one <= 16'hFFFE;
        sync_reset();
        chk(config_data, {16'h5678, 16'h1234, 16'hFFFE});
        fill();
        rd(4'h3, rv);
        chk(rv, 8'h9F);
        op(0, 1'b0, 21'h0);
        op(7, 1'b0, 21'h0);
        rd(4'h3, rv);
        chk(rv, 8'h9F);
        rd(4'h4, rv);
        chk(rv, 8'h3C);
        chk(48'(pulse_count), 48'h1);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        idle();
        rd(4'h3, rv);
        chk(rv, 8'h00);
        summarize();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule
